// ==== testbench/pin_source.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========
// far side of the timer pin
module pin_source (
  input wire logic clock,
  input wire logic clk_en,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic pin_i
);
  logic half_ff = 1'b0;
  logic ext_ff = 1'b0;
  logic last_ff = 1'b0;
  // two cycles per level so a one-cycle sampler sees every edge
  always_ff @(posedge clock) begin
    if (clk_en) begin
      half_ff <= ~half_ff;
      if (half_ff) ext_ff <= ~ext_ff;
    end
    last_ff <= pin_i;
  end
  // no pull on the line: an undriven pin wanders
  assign pin_i = !pin_oe_n ? pin_o : (clk_en ? ext_ff : ~last_ff);
endmodule : pin_source
`default_nettype wire

// ==== testbench/timer_control_pin_function_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "timer_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module timer_control_pin_function_bench;
  logic clock, rstn, cyc, stb, we, halt, ext_en, ack, pin_i, pin_o, oe_n, zev;
  logic [3:0] adr, sel;
  logic [31:0] dat, rd, dat_o;
  int err_total = 0, compares = 0, cycles = 0, n;
  localparam logic [15:0] LD = 16'h0400, SF = 16'h0200, FR = 16'h0100;
  localparam logic [15:0] RL = 16'h0020, ST = 16'h0010, CP = 16'h0008;
  localparam logic [15:0] PL = 16'h0004, DO = 16'h0002;
  timer_control_pin u_timer_control_pin (.clock(clock), .rstn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .emu_halt(halt), .timer_pin_i(pin_i), .timer_pin_o(pin_o),
    .timer_pin_oe_n(oe_n), .zero_event(zev));
  pin_source u_pin_source (.clock(clock), .clk_en(ext_en), .pin_o(pin_o),
    .pin_oe_n(oe_n), .pin_i(pin_i));
  // ==========
  // bus and measuring helpers
  function automatic logic [31:0] ctl(input logic [1:0] f,
    input logic [1:0] w, input logic [15:0] o);
    return {19'h0, f, 11'h0} | {24'h0, w, 6'h0} | {16'h0, o};
  endfunction : ctl
  task automatic xfer(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h3;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 50);
    `CHK("ack", 1'b1, ack)
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  task automatic chk_rd(input string nm, input logic [3:0] a,
    input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : chk_rd
  // gap in cycles up to the next zero event, 300 if none comes
  task automatic zw();
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (zev !== 1'b1 && n < 300);
  endtask : zw
  // the first active phase seen may predate the last write: skip the first two
  task automatic pw(input logic act);
    int k;
    k = 0;
    repeat (2) begin
      while (pin_o === act && k < 600) begin @(posedge clock); k++; end
      while (pin_o !== act && k < 600) begin @(posedge clock); k++; end
    end
    n = 0;
    while (pin_o === act && n < 300) begin @(posedge clock); n++; end
  endtask : pw
  // ==========
  // scenarios
  task automatic t_reset();
    chk_rd("ctrl", `ADDR_CONTROL, 32'h0010);
    chk_rd("prd", `ADDR_PERIOD, 32'hffff);
    repeat (20) @(posedge clock);
    chk_rd("cnt", `ADDR_COUNT, 32'hffff);
    `CHK("oe_n", 1'b1, oe_n)
    chk_rd("unmapped", 4'h2, 32'h0);
  endtask : t_reset
  task automatic t_load();
    xfer(1'b1, `ADDR_PRESCALE, 32'h1);
    xfer(1'b1, `ADDR_PERIOD, 32'h3);
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h0, 2'h0, LD | ST));
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h0, 2'h0, ST));
    chk_rd("cnt", `ADDR_COUNT, 32'h3);
    chk_rd("psc", `ADDR_PRESCALE, 32'h41);
    xfer(1'b1, `ADDR_PERIOD, 32'h7);
    chk_rd("cnt", `ADDR_COUNT, 32'h3);
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h0, 2'h0, RL));
    zw();
    zw();
    `CHK("gap", 16, n)
  endtask : t_load
  task automatic t_pulse();
    for (int w = 0; w < 4; w++) begin
      xfer(1'b1, `ADDR_CONTROL, ctl(2'h1, w[1:0], RL));
      pw(1'b1);
      `CHK("width", 1 << w, n)
    end
    `CHK("oe_n", 1'b0, oe_n)
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h1, 2'h3, RL | PL));
    pw(1'b0);
    `CHK("low", 8, n)
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h1, 2'h0, RL | CP));
    pw(1'b1);
    `CHK("half", 16, n)
  endtask : t_pulse
  task automatic t_gpio();
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h2, 2'h0, RL | DO));
    repeat (3) @(posedge clock);
    `CHK("gp_hi", 1'b1, pin_o)
    `CHK("oe_n", 1'b0, oe_n)
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h2, 2'h0, RL));
    repeat (3) @(posedge clock);
    `CHK("gp_lo", 1'b0, pin_o)
  endtask : t_gpio
  task automatic t_ext();
    ext_en <= 1'b1;
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h3, 2'h0, RL));
    chk_rd("err", `ADDR_CONTROL, ctl(2'h3, 2'h0, RL) | 32'h2000);
    chk_rd("err_clr", `ADDR_CONTROL, ctl(2'h3, 2'h0, RL));
    xfer(1'b1, `ADDR_PERIOD, 32'h3);
    zw();
    zw();
    `CHK("ext_gap", 32, n)
    `CHK("oe_n", 1'b1, oe_n)
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h0, 2'h0, RL));
    ext_en <= 1'b0;
    xfer(1'b0, `ADDR_CONTROL, 32'h0);
    `CHK("err2", 32'h2000, rd & 32'h2000)
  endtask : t_ext
  task automatic t_halt();
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h0, 2'h0, RL | FR));
    halt <= 1'b1;
    zw();
    zw();
    `CHK("free", 8, n)
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h0, 2'h0, RL));
    zw();
    `CHK("hard", 300, n)
    halt <= 1'b0;
    xfer(1'b1, `ADDR_CONTROL, ctl(2'h0, 2'h0, RL | SF));
    zw();
    halt <= 1'b1;
    zw();
    `CHK("soft", 8, n)
    zw();
    `CHK("held", 300, n)
    halt <= 1'b0;
  endtask : t_halt
  task automatic test_done();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // whole run needs well under two thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    {rstn, cyc, stb, we, halt, ext_en} = 6'h0;
    adr = 4'h0;
    sel = 4'h0;
    dat = 32'h0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_load();
    t_pulse();
    t_gpio();
    t_ext();
    t_halt();
    test_done();
  end
endmodule : timer_control_pin_function_bench
`default_nettype wire

// ==== verilog/timer_consts.svh ====
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// register byte addresses (word aligned, 32-bit wishbone)
`define ADDR_CONTROL 4'h0
`define ADDR_PRESCALE 4'h4
`define ADDR_PERIOD 4'h8
`define ADDR_COUNT 4'hc
// control field positions
`define BIT_ERROR 13
`define BIT_PIN_FUNCTION_SEL_HI 12
`define BIT_PIN_FUNCTION_SEL_LO 11
`define BIT_LOAD 10
`define BIT_SOFT 9
`define BIT_FREE 8
`define BIT_PULSE_WIDTH_SEL_HI 7
`define BIT_PULSE_WIDTH_SEL_LO 6
`define BIT_RELOAD 5
`define BIT_STOP 4
`define BIT_CP 3
`define BIT_OUTPUT_POLARITY 2
`define BIT_DOUT 1
// prescale register layout
`define PSC_HI 9
`define PSC_LO 6
`define PRESCALE_PERIOD_HI 3
`define PRESCALE_PERIOD_LO 0
// reset values
`define CONTROL_RESET 16'h0010
`define PERIOD_RESET 16'hffff
`define PRESCALE_PERIOD_RESET 4'h0
`endif

// ==== verilog/timer_control_pin.sv ====
// How it works
// - pin_function_sel 00: pin floats, internal clock
// - pin_function_sel 01: pin shows timer output events
// - pin_function_sel 10: pin driven from data-out bit
// - pin_function_sel 11: pin is input, counts rising edges
// - pin_function_sel field selects clock source too
// - load bit held copies periods to counts
// - free bit ignores emulation halt
// - hard stop halts timer immediately
// - soft stop halts at next zero
// - pulse width 1, 2, 4 or 8 clocks
// - auto-reload on zero restores the main count
// - stop bit resets to one, zero starts
// - prescaler ticks main count down
// - pulse or toggle mode by cp bit
// - polarity sets idle level of output
// - bad pin_function_sel change sets error flag
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "timer_consts.svh"
module timer_control_pin (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic emu_halt,
  input wire logic timer_pin_i,
  output logic timer_pin_o,
  output logic timer_pin_oe_n,
  output logic zero_event
);
  // ==========================================================
  // bus slave
  logic ack_ff;
  logic req;
  logic wr;
  logic lo_we;
  logic hi_we;
  logic [15:0] control_ff;
  logic [3:0] prescale_period_ff;
  logic [3:0] psc_ff;
  logic [15:0] period_ff;
  logic [15:0] count_ff;
  logic error_ff;
  logic out_level_ff;
  logic [3:0] width_cnt_ff;
  logic pin_sync_ff;
  logic pin_prev_ff;
  logic tick;
  logic running;
  logic psc_zero_ff;
  logic main_dec;
  logic hit_zero;
  logic reload_now;
  timer_pkg::pin_pin_function_sel_t pin_function_sel;
  timer_pkg::pin_pin_function_sel_t new_pin_function_sel;
  timer_pkg::run_state_t run_ff;

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i;
  assign lo_we = wr & wb_sel_i[0];
  assign hi_we = wr & wb_sel_i[1];
  assign wb_ack_o = ack_ff;

  // one wait state: ack one cycle after request, dropped next cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        `ADDR_CONTROL: wb_dat_o <= {16'h0, control_ff[15:14], error_ff,
          control_ff[12:1], 1'b0};
        `ADDR_PRESCALE: wb_dat_o <= {22'h0, psc_ff, 2'h0, prescale_period_ff};
        `ADDR_PERIOD: wb_dat_o <= {16'h0, period_ff};
        `ADDR_COUNT: wb_dat_o <= {16'h0, count_ff};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // control register
  assign pin_function_sel = timer_pkg::pin_pin_function_sel_t'(control_ff[`BIT_PIN_FUNCTION_SEL_HI:`BIT_PIN_FUNCTION_SEL_LO]);
  assign new_pin_function_sel =
    timer_pkg::pin_pin_function_sel_t'(wb_dat_i[`BIT_PIN_FUNCTION_SEL_HI:`BIT_PIN_FUNCTION_SEL_LO]);

  function automatic logic bad_change(input timer_pkg::pin_pin_function_sel_t from,
                                      input timer_pkg::pin_pin_function_sel_t to);
    bad_change = ((from == timer_pkg::PIN_TIMER_OUT ||
                   from == timer_pkg::PIN_GPIO_OUT) &&
                  (to == timer_pkg::PIN_HIZ || to == timer_pkg::PIN_EXT_CLOCK))
                 || (from == timer_pkg::PIN_EXT_CLOCK && to != from);
  endfunction : bad_change

  // the idle bit (15) is kept as plain storage only; the clock-change bit (14) is never written and reads zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      control_ff <= `CONTROL_RESET;
    end else begin
      if (lo_we && wb_adr_i == `ADDR_CONTROL) begin
        control_ff[7:1] <= wb_dat_i[7:1];
      end
      if (hi_we && wb_adr_i == `ADDR_CONTROL) begin
        control_ff[15] <= wb_dat_i[15];
        control_ff[12:8] <= wb_dat_i[12:8];
      end
    end
  end

  // set wins; reading control clears the flag
  always_ff @(posedge clock) begin
    if (!rstn) begin
      error_ff <= 1'b0;
    end else if (hi_we && wb_adr_i == `ADDR_CONTROL &&
                 bad_change(pin_function_sel, new_pin_function_sel)) begin
      error_ff <= 1'b1;
    end else if (req && !wb_we_i && wb_adr_i == `ADDR_CONTROL) begin
      error_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      prescale_period_ff <= `PRESCALE_PERIOD_RESET;
      period_ff <= `PERIOD_RESET;
    end else begin
      if (lo_we && wb_adr_i == `ADDR_PRESCALE) begin
        prescale_period_ff <= wb_dat_i[`PRESCALE_PERIOD_HI:`PRESCALE_PERIOD_LO];
      end
      if (wb_adr_i == `ADDR_PERIOD) begin
        if (lo_we) begin
          period_ff[7:0] <= wb_dat_i[7:0];
        end
        if (hi_we) begin
          period_ff[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // ==========================================================
  // clock source and emulation stop
  // pin clock is sampled, so external rate must stay below clock/2
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_sync_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      pin_sync_ff <= timer_pin_i;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  assign tick = (pin_function_sel == timer_pkg::PIN_EXT_CLOCK) ?
    (pin_sync_ff & ~pin_prev_ff) : 1'b1;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      run_ff <= timer_pkg::RUN_FREE;
    end else begin
      case (run_ff)
        timer_pkg::RUN_FREE: begin
          if (emu_halt && !control_ff[`BIT_FREE]) begin
            run_ff <= control_ff[`BIT_SOFT] ?
              timer_pkg::RUN_SOFT_WAIT : timer_pkg::RUN_HALTED;
          end
        end
        timer_pkg::RUN_SOFT_WAIT: begin
          if (!emu_halt || control_ff[`BIT_FREE]) begin
            run_ff <= timer_pkg::RUN_FREE;
          end else if (hit_zero) begin
            run_ff <= timer_pkg::RUN_HALTED;
          end
        end
        timer_pkg::RUN_HALTED: begin
          if (!emu_halt || control_ff[`BIT_FREE]) begin
            run_ff <= timer_pkg::RUN_FREE;
          end
        end
        default: run_ff <= timer_pkg::RUN_FREE;
      endcase
    end
  end

  assign running = !control_ff[`BIT_STOP] &&
    run_ff != timer_pkg::RUN_HALTED &&
    !(emu_halt && !control_ff[`BIT_FREE] && !control_ff[`BIT_SOFT]);

  // ==========================================================
  // counters
  assign main_dec = running && tick && psc_zero_ff;
  assign hit_zero = main_dec && count_ff == 16'h1;
  // the count rests at zero for one main step, so one period is
  // (prescale period + 1) x (main period + 1) ticks
  assign reload_now = main_dec && count_ff == 16'h0 &&
    control_ff[`BIT_RELOAD];
  assign zero_event = hit_zero;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      psc_ff <= `PRESCALE_PERIOD_RESET;
      count_ff <= `PERIOD_RESET;
      psc_zero_ff <= 1'b0;
    end else if (control_ff[`BIT_LOAD]) begin
      psc_ff <= prescale_period_ff;
      count_ff <= period_ff;
      psc_zero_ff <= 1'b0;
    end else if (running && tick) begin
      psc_zero_ff <= (psc_ff == 4'h0);
      psc_ff <= (psc_ff == 4'h0) ? prescale_period_ff : psc_ff - 4'h1;
      if (main_dec) begin
        if (reload_now) begin
          // prescaler restarted from its period on the tick before;
          // loading it again here would stretch each period by a tick
          count_ff <= period_ff;
        end else begin
          count_ff <= count_ff - 16'h1;
        end
      end
    end
  end

  // ==========================================================
  // pin output
  always_ff @(posedge clock) begin
    if (!rstn) begin
      out_level_ff <= 1'b0;
      width_cnt_ff <= 4'h0;
    end else if (pin_function_sel != timer_pkg::PIN_TIMER_OUT) begin
      out_level_ff <= 1'b0;
      width_cnt_ff <= 4'h0;
    end else if (control_ff[`BIT_CP]) begin
      width_cnt_ff <= 4'h0;
      if (hit_zero) begin
        out_level_ff <= ~out_level_ff;
      end
    end else if (hit_zero) begin
      out_level_ff <= 1'b1;
      width_cnt_ff <= 4'(1 << control_ff[`BIT_PULSE_WIDTH_SEL_HI:`BIT_PULSE_WIDTH_SEL_LO]) - 4'h1;
    end else if (width_cnt_ff != 4'h0) begin
      width_cnt_ff <= width_cnt_ff - 4'h1;
    end else begin
      out_level_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      timer_pin_o <= 1'b0;
      timer_pin_oe_n <= 1'b1;
    end else begin
      case (pin_function_sel)
        timer_pkg::PIN_TIMER_OUT: begin
          timer_pin_o <= out_level_ff ^ control_ff[`BIT_OUTPUT_POLARITY];
          timer_pin_oe_n <= 1'b0;
        end
        timer_pkg::PIN_GPIO_OUT: begin
          timer_pin_o <= control_ff[`BIT_DOUT];
          timer_pin_oe_n <= 1'b0;
        end
        default: begin
          timer_pin_o <= 1'b0;
          timer_pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  load_copy_a: assert property (@(posedge clock) disable iff (!rstn)
    control_ff[`BIT_LOAD] |=> count_ff == $past(period_ff))
    else $error("load did not copy period");
  stop_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    control_ff[`BIT_STOP] && !control_ff[`BIT_LOAD] |=> $stable(count_ff))
    else $error("stopped count moved");
  hiz_pin_a: assert property (@(posedge clock) disable iff (!rstn)
    pin_function_sel == timer_pkg::PIN_HIZ && $stable(pin_function_sel) |=> timer_pin_oe_n)
    else $error("pin driven in hiz mode");
  gpio_pin_a: assert property (@(posedge clock) disable iff (!rstn)
    pin_function_sel == timer_pkg::PIN_GPIO_OUT |=> !timer_pin_oe_n &&
    timer_pin_o == $past(control_ff[`BIT_DOUT]))
    else $error("gpio level wrong");
  auto_reload_a: assert property (@(posedge clock) disable iff (!rstn)
    reload_now && !control_ff[`BIT_LOAD] |=> count_ff == $past(period_ff))
    else $error("auto reload missed");
  hard_stop_a: assert property (@(posedge clock) disable iff (!rstn)
    emu_halt && !control_ff[`BIT_FREE] && !control_ff[`BIT_SOFT]
    |-> !main_dec)
    else $error("hard stop ignored");
  sequence pulse_start_s;
    hit_zero && pin_function_sel == timer_pkg::PIN_TIMER_OUT && !control_ff[`BIT_CP]
    && control_ff[`BIT_PULSE_WIDTH_SEL_HI:`BIT_PULSE_WIDTH_SEL_LO] == 2'b01;
  endsequence
  pulse_two_a: assert property (@(posedge clock) disable iff (!rstn)
    pulse_start_s ##1 $stable(control_ff) |-> out_level_ff ##1 out_level_ff)
    else $error("pulse width wrong");
  err_set_a: assert property (@(posedge clock) disable iff (!rstn)
    hi_we && wb_adr_i == `ADDR_CONTROL && bad_change(pin_function_sel, new_pin_function_sel)
    |=> error_ff)
    else $error("pin error not flagged");
endmodule : timer_control_pin
`default_nettype wire

// ==== verilog/timer_pkg.sv ====
`default_nettype none
package timer_pkg;
  typedef enum logic [1:0] {
    PIN_HIZ,
    PIN_TIMER_OUT,
    PIN_GPIO_OUT,
    PIN_EXT_CLOCK
  } pin_pin_function_sel_t;
  typedef enum logic [1:0] {
    RUN_FREE,
    RUN_SOFT_WAIT,
    RUN_HALTED
  } run_state_t;
endpackage : timer_pkg
`default_nettype wire
